// *** verilog/sbac_boot_cfg.sv ***
// Behaviour
// - After boot, per-port host addresses from strap index.
// - Second bus addresses come from loaded configuration.
// - Loader mode answers only port A address.
// - Address byte: 0100, port bit, index minus one.
// - Byte after address selects host command.
// - Route transaction by which port address matched.
// - Write framing: address, write bit, acknowledged bytes.
// - Sample straps, try memory, else wait host.
// - Configuration memory sits at address 0x50.
// - Always-sink strap pairs, indexes one to four.
// - Three-amp strap pairs, indexes one to four.
// - One-half-amp strap pairs, indexes one to four.
// - High-voltage pairs: sink, application mode, PD.
// - Safe pairs: sink stays disabled, PD off until application mode.
module sbac_boot_cfg
  import sbac_pkg::*;
#(
  parameter int SETTLE_CYC = STRAP_SETTLE_CYC // Strap settle cycles.
) (
  input wire logic sys_clk, // 40 MHz clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [STRAP_W-1:0] strap_input_first, // First strap value, asynchronous.
  input wire logic [STRAP_W-1:0] strap_input_second, // Second strap value, asynchronous.
  input wire logic eeprom_done, // Controller bus probe finished, one-cycle pulse.
  input wire logic eeprom_ack, // Memory answered the probe, valid with done.
  input wire logic host_cfg_loaded, // Host finished loading configuration, pulse.
  input wire logic addr_valid, // Address byte received on host bus, pulse.
  input wire logic [7:0] addr_byte, // Received address byte with direction bit.
  input wire logic sub_valid, // Sub-address byte received, pulse.
  input wire logic [7:0] sub_byte, // Received sub-address byte.
  input wire logic [6:0] cfg_second_addr_a, // Port A second-bus address from configuration.
  input wire logic [6:0] cfg_second_addr_b, // Port B second-bus address from configuration.
  output logic eeprom_probe, // Start probe of configuration memory, pulse.
  output logic [6:0] eeprom_addr, // Memory target address.
  output logic [6:0] host_addr_a, // Port A host bus address.
  output logic [6:0] host_addr_b, // Port B host bus address.
  output logic host_addr_b_en, // Port B address is answered.
  output logic [6:0] second_addr_a, // Port A second-bus address.
  output logic [6:0] second_addr_b, // Port B second-bus address.
  output logic addr_ack, // Address matched, acknowledge it, pulse.
  output logic addr_port_b, // Transaction targets port B.
  output logic addr_read, // Transaction direction is read.
  output logic cmd_valid, // Host command selected, pulse.
  output logic [7:0] cmd_code, // Selected host command.
  output logic cmd_port_b, // Command belongs to port B.
  output logic app_mode, // Device is in application mode.
  output logic [2:0] policy, // Dead-battery policy code.
  output logic sink_any, // Sink regardless of offered current.
  output logic sink_3a, // Sink only at 3.0A offered.
  output logic sink_1a5, // Sink only at 1.5A offered.
  output logic pd_en // PD PHY enabled.
);

  // Two-flop synchronisers for the strap pins.
  logic [STRAP_W-1:0] s1_first_q, s2_first_q, s1_second_q, s2_second_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_first_q <= '0;
      s2_first_q <= '0;
      s1_second_q <= '0;
      s2_second_q <= '0;
    end else begin
      s1_first_q <= strap_input_first;
      s2_first_q <= s1_first_q;
      s1_second_q <= strap_input_second;
      s2_second_q <= s1_second_q;
    end
  end

  // Table decode of the synchronised straps.
  sbac_strap_s dec;
  sbac_strap_decode u_dec (
    .strap_first(s2_first_q),
    .strap_second(s2_second_q),
    .setting(dec)
  );

  // Boot sequencer state.
  sbac_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d; // Settle counter; straps move while supplies ramp.
  sbac_strap_s cfg_q, cfg_d; // Latched strap setting, frozen after sampling.
  logic probe_q, probe_d;
  logic app_q, app_d;

  // Next-state logic for the boot sequence.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cfg_d = cfg_q;
    probe_d = 1'b0;
    app_d = app_q;
    case (st_q)
      SBAC_ST_SETTLE: begin
        // Wait for the straps to settle before sampling them.
        if (cnt_q >= 16'(SETTLE_CYC - 1)) begin
          st_d = SBAC_ST_STRAP;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      SBAC_ST_STRAP: begin
        // Straps first, then the memory probe.
        cfg_d = dec;
        if (dec.policy == SBAC_HIGH_VOLTAGE) begin
          // High voltage goes straight to application mode; no memory load.
          app_d = 1'b1;
          st_d = SBAC_ST_APP;
        end else begin
          probe_d = 1'b1;
          st_d = SBAC_ST_EEPROM;
        end
      end
      SBAC_ST_EEPROM: begin
        // A silent memory hands loading to the host.
        if (eeprom_done) begin
          if (eeprom_ack) begin
            app_d = 1'b1;
            st_d = SBAC_ST_APP;
          end else begin
            st_d = SBAC_ST_WAIT_HOST;
          end
        end
      end
      SBAC_ST_WAIT_HOST: begin
        // Loader mode; only port A answers until the host loads a bundle.
        if (host_cfg_loaded) begin
          app_d = 1'b1;
          st_d = SBAC_ST_APP;
        end
      end
      SBAC_ST_APP: begin
        app_d = 1'b1;
      end
      default: begin
        st_d = SBAC_ST_SETTLE;
      end
    endcase
  end

  // Registers for the boot sequence.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= SBAC_ST_SETTLE;
      cnt_q <= 16'h0000;
      cfg_q <= '{idx: IDX_RESET, policy: SBAC_SAFE};
      probe_q <= 1'b0;
      app_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cfg_q <= cfg_d;
      probe_q <= probe_d;
      app_q <= app_d;
    end
  end

  // Address and power outputs computed from latched state and the second-bus configuration inputs.
  logic [6:0] ha_d, hb_d, sa_d, sb_d;
  logic hb_en_d;
  sbac_power_s pw_d;
  always_comb begin
    ha_d = {ADDR_HI_NIBBLE, 1'b0, cfg_q.idx};
    hb_d = {ADDR_HI_NIBBLE, 1'b1, cfg_q.idx};
    hb_en_d = app_q;
    // Second bus addresses follow the loaded configuration only.
    sa_d = app_q ? cfg_second_addr_a : ADDR_RESET;
    sb_d = app_q ? cfg_second_addr_b : ADDR_RESET;
    pw_d.sink_any = (cfg_q.policy == SBAC_ALWAYS_SINK) ||
                    (cfg_q.policy == SBAC_HIGH_VOLTAGE);
    pw_d.sink_3a = (cfg_q.policy == SBAC_THREE_AMP);
    pw_d.sink_1a5 = (cfg_q.policy == SBAC_ONE_HALF_AMP);
    // PD stays off until a configuration is in, except in high voltage.
    pw_d.pd_en = app_q;
    if (st_q == SBAC_ST_SETTLE) begin
      pw_d = '0;
    end
  end

  // Address matching and command selection on the host bus.
  logic ack_d, port_b_d, rd_d, cmd_v_d, cmd_pb_d, sel_v_q, sel_pb_q, sel_v_d, sel_pb_d;
  logic [7:0] cmd_d;
  sbac_match_s m;
  always_comb begin
    m.hit = 1'b0;
    m.port_b = 1'b0;
    if (addr_byte[7:1] == ha_d) begin
      m.hit = 1'b1;
    end else if (hb_en_d && addr_byte[7:1] == hb_d) begin
      m.hit = 1'b1;
      m.port_b = 1'b1;
    end
    ack_d = addr_valid && m.hit && (st_q == SBAC_ST_WAIT_HOST || st_q == SBAC_ST_APP);
    port_b_d = ack_d ? m.port_b : addr_port_b;
    rd_d = ack_d ? addr_byte[0] : addr_read;
    sel_v_d = ack_d ? !addr_byte[0] : sel_v_q; // First write byte is the sub-address.
    sel_pb_d = ack_d ? m.port_b : sel_pb_q;
    cmd_v_d = 1'b0;
    cmd_d = cmd_code;
    cmd_pb_d = cmd_port_b;
    if (addr_valid && !ack_d) begin
      sel_v_d = 1'b0; // Another target's frame; ignore its bytes.
    end else if (sub_valid && sel_v_q) begin
      cmd_v_d = 1'b1;
      cmd_d = sub_byte;
      cmd_pb_d = sel_pb_q;
      // A write address taken in the same cycle re-arms the selector, so the set wins.
      sel_v_d = ack_d && !addr_byte[0];
    end
  end

  // Output registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      host_addr_a <= ADDR_RESET;
      host_addr_b <= ADDR_RESET;
      host_addr_b_en <= 1'b0;
      second_addr_a <= ADDR_RESET;
      second_addr_b <= ADDR_RESET;
      eeprom_probe <= 1'b0;
      eeprom_addr <= EEPROM_ADDR;
      addr_ack <= 1'b0;
      addr_port_b <= 1'b0;
      addr_read <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= 8'h00;
      cmd_port_b <= 1'b0;
      sel_v_q <= 1'b0;
      sel_pb_q <= 1'b0;
      app_mode <= 1'b0;
      policy <= 3'h0;
      sink_any <= 1'b0;
      sink_3a <= 1'b0;
      sink_1a5 <= 1'b0;
      pd_en <= 1'b0;
    end else begin
      host_addr_a <= ha_d;
      host_addr_b <= hb_d;
      host_addr_b_en <= hb_en_d;
      second_addr_a <= sa_d;
      second_addr_b <= sb_d;
      eeprom_probe <= probe_q;
      eeprom_addr <= EEPROM_ADDR;
      addr_ack <= ack_d;
      addr_port_b <= port_b_d;
      addr_read <= rd_d;
      cmd_valid <= cmd_v_d;
      cmd_code <= cmd_d;
      cmd_port_b <= cmd_pb_d;
      sel_v_q <= sel_v_d;
      sel_pb_q <= sel_pb_d;
      app_mode <= app_q;
      policy <= cfg_q.policy;
      sink_any <= pw_d.sink_any;
      sink_3a <= pw_d.sink_3a;
      sink_1a5 <= pw_d.sink_1a5;
      pd_en <= pw_d.pd_en;
    end
  end

  // Port B never acknowledged outside application mode.
  loader_port_a_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    addr_ack && addr_port_b |-> $past(app_q)) else $error("port B answered in loader mode");

  // A memory probe follows strap sampling by two cycles.
  probe_after_strap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == SBAC_ST_STRAP && dec.policy != SBAC_HIGH_VOLTAGE) |=> ##1 eeprom_probe)
    else $error("probe missing after strap sample");

  // Silent memory leads to waiting for the host.
  sequence nack_done_s;
    st_q == SBAC_ST_EEPROM && eeprom_done && !eeprom_ack;
  endsequence
  host_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    nack_done_s |=> st_q == SBAC_ST_WAIT_HOST) else $error("no host wait");

  // Port B address output carries the fixed nibble, port bit and index.
  // The first edge after release still shows the reset value, so that edge is skipped.
  addr_layout_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(nrst) |-> host_addr_b[6:3] == ADDR_HI_NIBBLE && host_addr_b[2] &&
    host_addr_b[1:0] == $past(cfg_q.idx))
    else $error("address layout wrong");

  // Safe policy keeps sink off and PD off before configuration.
  safe_sink_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    policy == SBAC_SAFE && !app_mode |-> !sink_any && !sink_3a && !sink_1a5 && !pd_en)
    else $error("safe policy drives power");

  // High voltage reaches application mode within three cycles of sampling.
  high_volt_app_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == SBAC_ST_STRAP && dec.policy == SBAC_HIGH_VOLTAGE) |-> ##[1:3] (app_mode && pd_en))
    else $error("high voltage did not enter application mode");

  // Command routes to the port of the matched address.
  cmd_route_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cmd_valid |-> cmd_port_b == $past(sel_pb_q) && cmd_code == $past(sub_byte))
    else $error("command routed wrong");

  // Memory address stays fixed.
  eeprom_addr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    eeprom_addr == 7'h50) else $error("memory address wrong");

endmodule

// *** common/sbac_pkg.sv ***
package sbac_pkg;

  // Strap decoded values are three bits each.
  localparam int STRAP_W = 3;

  // Address byte layout: fixed upper nibble, port bit, index field.
  localparam logic [3:0] ADDR_HI_NIBBLE = 4'h4;
  localparam int ADDR_PORT_BIT = 3;
  localparam int ADDR_IDX_MSB = 2;
  localparam int ADDR_IDX_LSB = 1;

  // Seven-bit address of the configuration memory on the controller bus.
  localparam logic [6:0] EEPROM_ADDR = 7'h50;

  // Reset values.
  localparam logic [1:0] IDX_RESET = 2'h0;
  localparam logic [6:0] ADDR_RESET = 7'h00;

  // Settling time of the strap pins before sampling, in ns, and its cycle count.
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Dead-battery sink policies.
  typedef enum logic [2:0] {
    SBAC_SAFE = 3'b000,
    SBAC_ALWAYS_SINK = 3'b001,
    SBAC_THREE_AMP = 3'b010,
    SBAC_ONE_HALF_AMP = 3'b011,
    SBAC_HIGH_VOLTAGE = 3'b100
  } sbac_policy_e;

  // Boot sequencer states.
  typedef enum logic [2:0] {
    SBAC_ST_SETTLE = 3'b000,
    SBAC_ST_STRAP = 3'b001,
    SBAC_ST_EEPROM = 3'b010,
    SBAC_ST_WAIT_HOST = 3'b011,
    SBAC_ST_APP = 3'b100
  } sbac_state_e;

  // Decoded strap setting.
  typedef struct packed {
    logic [1:0] idx;
    sbac_policy_e policy;
  } sbac_strap_s;

  // Sink-path controls derived from the policy, and the PD enable from application mode.
  typedef struct packed {
    logic sink_any;
    logic sink_3a;
    logic sink_1a5;
    logic pd_en;
  } sbac_power_s;

  // One address match result on the host target bus.
  typedef struct packed {
    logic hit;
    logic port_b;
  } sbac_match_s;

endpackage

// *** verilog/sbac_strap_decode.sv ***
// Pure table decode of the two strap values; unlisted pairs fall to safe, index 1.
module sbac_strap_decode
  import sbac_pkg::*;
(
  input wire logic [STRAP_W-1:0] strap_first, // First strap decoded value.
  input wire logic [STRAP_W-1:0] strap_second, // Second strap decoded value.
  output sbac_strap_s setting // Index and policy.
);

  // Table lookup keyed on the concatenated pair.
  always_comb begin
    setting.idx = 2'h0;
    setting.policy = SBAC_SAFE;
    case ({strap_first, strap_second})
      // Always sink group.
      6'o75: begin setting.idx = 2'h0; setting.policy = SBAC_ALWAYS_SINK; end
      6'o55: begin setting.idx = 2'h1; setting.policy = SBAC_ALWAYS_SINK; end
      6'o20: begin setting.idx = 2'h2; setting.policy = SBAC_ALWAYS_SINK; end
      6'o17: begin setting.idx = 2'h3; setting.policy = SBAC_ALWAYS_SINK; end
      // Three amp group.
      6'o74: begin setting.idx = 2'h0; setting.policy = SBAC_THREE_AMP; end
      6'o44: begin setting.idx = 2'h1; setting.policy = SBAC_THREE_AMP; end
      6'o30: begin setting.idx = 2'h2; setting.policy = SBAC_THREE_AMP; end
      6'o27: begin setting.idx = 2'h3; setting.policy = SBAC_THREE_AMP; end
      // One and a half amp group.
      6'o76: begin setting.idx = 2'h0; setting.policy = SBAC_ONE_HALF_AMP; end
      6'o66: begin setting.idx = 2'h1; setting.policy = SBAC_ONE_HALF_AMP; end
      6'o65: begin setting.idx = 2'h2; setting.policy = SBAC_ONE_HALF_AMP; end
      6'o67: begin setting.idx = 2'h3; setting.policy = SBAC_ONE_HALF_AMP; end
      // High voltage group.
      6'o73: begin setting.idx = 2'h0; setting.policy = SBAC_HIGH_VOLTAGE; end
      6'o33: begin setting.idx = 2'h1; setting.policy = SBAC_HIGH_VOLTAGE; end
      6'o40: begin setting.idx = 2'h2; setting.policy = SBAC_HIGH_VOLTAGE; end
      6'o37: begin setting.idx = 2'h3; setting.policy = SBAC_HIGH_VOLTAGE; end
      // Safe group.
      6'o70: begin setting.idx = 2'h0; setting.policy = SBAC_SAFE; end
      6'o00: begin setting.idx = 2'h1; setting.policy = SBAC_SAFE; end
      6'o60: begin setting.idx = 2'h2; setting.policy = SBAC_SAFE; end
      6'o57: begin setting.idx = 2'h3; setting.policy = SBAC_SAFE; end
      // Anything else is treated as safe with the first index.
      default: begin setting.idx = 2'h0; setting.policy = SBAC_SAFE; end
    endcase
  end

endmodule

// *** tb/sbac_far_model.sv ***
// Far side of the boot loader: the configuration memory behind the controller bus engine.
module sbac_far_model
  import sbac_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic nrst, // Reset, active low.
  input wire logic eeprom_probe, // Probe request pulse.
  input wire logic [6:0] eeprom_addr, // Address the probe is sent to.
  input wire logic present, // A memory is fitted on this board.
  input wire logic [3:0] lat, // Extra answer delay in cycles.
  output logic eeprom_done, // Probe finished pulse.
  output logic eeprom_ack // Memory answered, valid with done.
);
  timeunit 1ns;
  timeprecision 1ps;

  int wait_q; // Cycles left before the answer, zero when idle.
  logic hit_q; // The probe reached a fitted memory at its own address.

  // Answers on the falling edge, as the bench drives, after a slow or prompt delay.
  always @(negedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q = 0;
      hit_q = 1'b0;
      eeprom_done <= 1'b0;
      eeprom_ack <= 1'b0;
    end else begin
      eeprom_done <= (wait_q == 1);
      // Outside an answer the flag toggles, so a stale value can never look valid.
      eeprom_ack <= (wait_q == 1) ? hit_q : ~eeprom_ack;
      if (wait_q > 0) begin
        wait_q = wait_q - 1;
      end
      if (eeprom_probe === 1'b1) begin
        // Each board has its own memory, and it answers only at its fixed address.
        hit_q = present && (eeprom_addr === EEPROM_ADDR);
        wait_q = lat + 1;
      end
    end
  end
endmodule

// *** tb/sbac_boot_cfg_tb_top.sv ***
// Sweeps every strap pair through a full boot and checks the host address decode.
module sbac_boot_cfg_tb_top
  import sbac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SETTLE = 2; // Short settle keeps the 64-pair sweep quick.
  localparam int LIMIT = 20000; // Cycle ceiling; the sweep needs about a seventh of it.
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] strap_first = 3'h0, strap_second = 3'h0;
  logic host_cfg_loaded = 1'b0, addr_valid = 1'b0, sub_valid = 1'b0, present = 1'b0;
  logic [7:0] addr_byte = 8'h00, sub_byte = 8'h00, cmd_code;
  logic [6:0] cfg_a = 7'h00, cfg_b = 7'h00, eeprom_addr, host_addr_a, host_addr_b;
  logic [6:0] second_addr_a, second_addr_b;
  logic [3:0] lat = 4'h0;
  logic [2:0] policy;
  logic eeprom_done, eeprom_ack, eeprom_probe, host_addr_b_en, addr_ack, addr_port_b;
  logic addr_read, cmd_valid, cmd_port_b, app_mode, sink_any, sink_3a, sink_1a5, pd_en;
  logic [31:0] rnd = 32'h3292_5284;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  // Strap table in groups of four: always, three amp, one and a half amp, high volt, safe.
  int tf[20] = '{7, 5, 2, 1, 7, 4, 3, 2, 7, 6, 6, 6, 7, 3, 4, 3, 7, 0, 6, 5};
  int ts[20] = '{5, 5, 0, 7, 4, 4, 0, 7, 6, 6, 5, 7, 3, 3, 0, 7, 0, 0, 0, 7};

  sbac_boot_cfg #(.SETTLE_CYC(SETTLE)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .strap_input_first(strap_first),
    .strap_input_second(strap_second), .eeprom_done(eeprom_done), .eeprom_ack(eeprom_ack),
    .host_cfg_loaded(host_cfg_loaded), .addr_valid(addr_valid), .addr_byte(addr_byte),
    .sub_valid(sub_valid), .sub_byte(sub_byte), .cfg_second_addr_a(cfg_a),
    .cfg_second_addr_b(cfg_b), .eeprom_probe(eeprom_probe), .eeprom_addr(eeprom_addr),
    .host_addr_a(host_addr_a), .host_addr_b(host_addr_b), .host_addr_b_en(host_addr_b_en),
    .second_addr_a(second_addr_a), .second_addr_b(second_addr_b), .addr_ack(addr_ack),
    .addr_port_b(addr_port_b), .addr_read(addr_read), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_port_b(cmd_port_b), .app_mode(app_mode), .policy(policy),
    .sink_any(sink_any), .sink_3a(sink_3a), .sink_1a5(sink_1a5), .pd_en(pd_en));

  sbac_far_model far (
    .sys_clk(sys_clk), .nrst(nrst), .eeprom_probe(eeprom_probe), .eeprom_addr(eeprom_addr),
    .present(present), .lat(lat), .eeprom_done(eeprom_done), .eeprom_ack(eeprom_ack));

  // Free-running 40 MHz clock.
  always #12.5 sys_clk = ~sys_clk;

  // A hang is cut short here and reported like any other failure.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reference decode of a strap pair into index and policy code; unlisted pairs stay safe.
  task automatic ref_decode(input int a, input int b, output int idx, output int pol);
    int codes[5] = '{1, 2, 3, 4, 0};
    idx = 0;
    pol = 0;
    for (int i = 0; i < 20; i++) begin
      if (tf[i] == a && ts[i] == b) begin
        idx = i % 4;
        pol = codes[i / 4];
      end
    end
  endtask

  // One byte on the host bus, entered at a falling edge: address (sub 0) or sub-address.
  // The answer is counted over three cycles, so a doubled or missing pulse shows up.
  task automatic xfer(input int sub, input logic [7:0] v, input int ok, input int pb);
    int seen;
    logic [7:0] got;
    logic port;
    seen = 0;
    got = 8'h00;
    port = 1'b0;
    if (sub == 1) begin
      sub_byte = v;
      sub_valid = 1'b1;
    end else begin
      addr_byte = v;
      addr_valid = 1'b1;
    end
    // Three cycles per byte stand for the byte engine's hand-over; a host bus clock at or
    // below 400 kHz only widens the gap, and the design does not depend on the gap.
    for (int i = 0; i < 3; i++) begin
      @(negedge sys_clk);
      if (i == 0) begin
        addr_valid = 1'b0;
        sub_valid = 1'b0;
      end else if (i == 1) begin
        // Idle bytes change once the byte is taken, so the design cannot lean on them.
        addr_byte = ~addr_byte;
        sub_byte = ~sub_byte;
      end
      if (sub == 1 && cmd_valid === 1'b1) begin
        seen++;
        got = cmd_code;
        port = cmd_port_b;
      end
      if (sub == 0 && addr_ack === 1'b1) begin
        seen++;
        got = {7'h00, addr_read};
        port = addr_port_b;
      end
    end
    chk(seen, ok);
    if (ok == 1) begin
      chk(port, pb);
      chk(got, (sub == 1) ? v : {7'h00, v[0]});
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Every strap pair gets its own reset and boot, which also exercises mid-run resets.
  initial begin
    int idx, pol, hv;
    logic [6:0] pa, pb;
    for (int p = 0; p < 64; p++) begin
      rnd = lfsr(rnd);
      ref_decode(p / 8, p % 8, idx, pol);
      hv = (pol == 4);
      pa = {ADDR_HI_NIBBLE, 1'b0, 2'(idx)};
      pb = {ADDR_HI_NIBBLE, 1'b1, 2'(idx)};
      @(negedge sys_clk);
      nrst = 1'b0;
      strap_first = 3'(p / 8);
      strap_second = 3'(p % 8);
      present = rnd[0] && !hv;
      lat = rnd[7:4];
      cfg_a = rnd[14:8];
      cfg_b = rnd[22:16];
      repeat (3) @(negedge sys_clk);
      nrst = 1'b1;
      // Bounded wait for the probe, or for application mode on high voltage.
      repeat (20) if (eeprom_probe !== 1'b1 && app_mode !== 1'b1) @(negedge sys_clk);
      chk(eeprom_probe, !hv);
      @(negedge sys_clk);
      chk(policy, pol);
      chk(sink_any, pol == 1 || hv);
      chk(sink_3a, pol == 2);
      chk(sink_1a5, pol == 3);
      chk(pd_en, hv);
      chk(app_mode, hv);
      chk(host_addr_a, pa);
      chk(host_addr_b, pb);
      chk(eeprom_addr, 7'h50);
      if (!hv && !present) begin
        // No memory answered: the host loads over the target bus at the port A address.
        repeat (lat + 4) @(negedge sys_clk);
        xfer(0, {pb, 1'b0}, 0, 0);
        xfer(0, {pa, 1'b0}, 1, 0);
        xfer(1, rnd[31:24], 1, 0);
        chk(second_addr_a, 7'h00);
        chk(second_addr_b, 7'h00);
        chk(host_addr_b_en, 1'b0);
        host_cfg_loaded = 1'b1;
        @(negedge sys_clk);
        host_cfg_loaded = 1'b0;
      end
      repeat (24) if (app_mode !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      chk(app_mode, 1);
      chk(pd_en, 1);
      chk(host_addr_b_en, 1);
      chk(second_addr_a, cfg_a);
      chk(second_addr_b, cfg_b);
      xfer(0, {pb, 1'b1}, 1, 1);
      xfer(1, rnd[31:24], 0, 0);
      xfer(0, {pa ^ 7'h02, 1'b0}, 0, 0);
      xfer(0, {pb, 1'b0}, 1, 1);
      xfer(1, rnd[23:16], 1, 1);
      xfer(1, rnd[15:8], 0, 0);
    end
    give_verdict();
  end
endmodule
